// *** design/sacs_pkg.sv ***
/*
 * Constants and types shared by the converter control sequencer files.
 * Assumes one 25 MHz system clock that also stands for the oscillator
 * rate from which the bit period divisors are taken.
 */
`default_nettype none
package sacs_pkg;

    localparam int RESULT_W      = 10;
    localparam int REG_W         = 8;
    localparam int INSTR_CLKS    = 4;    // one instruction cycle in system clocks
    localparam int TAD_PER_CONV  = 11;
    localparam int SETUP_TADS    = 1;
    localparam int ABORT_TADS    = 2;
    localparam int DIV_CNT_W     = 6;
    localparam int TAD_CNT_W     = 4;
    localparam int INSTR_CNT_W   = 3;

    localparam logic [1:0] CLKSEL_RC_TAIL = 2'h3;
    localparam logic [RESULT_W-1:0] SAR_FIRST_TRIAL = 10'h200;
    localparam logic [REG_W-1:0]    RESULT_RST      = 8'h00;
    localparam logic [3:0]          CHANNEL_RST     = 4'h0;
    localparam logic [2:0]          CLKSEL_RST      = 3'h0;
    localparam logic                JUSTIFY_RIGHT   = 1'b1;

    typedef struct packed {
        logic       result_justify;
        logic       reference_select;
        logic [3:0] channel_select;
        logic [2:0] conversion_clock_select;
    } sacs_cfg_type;

    typedef struct packed {
        logic [REG_W-1:0] result_high;
        logic [REG_W-1:0] result_low;
    } sacs_result_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RC_DELAY,
        ST_SETUP,
        ST_CONVERT,
        ST_ABORT
    } sacs_state_type;

endpackage
`default_nettype wire

// *** design/sacs_tad_clock.sv ***
/*
 * Bit period tick generator: a divider off the system clock, or the
 * rising edges of the dedicated RC oscillator pin after synchronisation.
 * Assumes the RC oscillator is far slower than the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sacs_tad_clock (
    input  wire logic       clk,          // system clock
    input  wire logic       sys_rst,      // synchronous reset
    input  wire logic [2:0] clk_sel,      // conversion clock select code
    input  wire logic       restart,      // realign divider
    input  wire logic       rc_osc_pin,   // dedicated RC oscillator
    output logic            tad_tick      // one pulse per bit period
);
    logic                           rc_meta_ff;
    logic                           rc_sync_ff;
    logic                           rc_prev_ff;
    logic [sacs_pkg::DIV_CNT_W-1:0] div_cnt_ff;
    logic [sacs_pkg::DIV_CNT_W-1:0] div_last;
    logic [2:0]                     div_shift;
    logic                           use_rc;

    assign use_rc    = (clk_sel[1:0] == sacs_pkg::CLKSEL_RC_TAIL);
    // divisor is 2^(1 + sel[2] + 2*sel[1:0]) giving 2,4,8,16,32,64
    assign div_shift = {clk_sel[1:0], clk_sel[2]};
    assign div_last  = sacs_pkg::DIV_CNT_W'((7'h02 << div_shift) - 7'h01);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rc_meta_ff <= 1'b0;
            rc_sync_ff <= 1'b0;
            rc_prev_ff <= 1'b0;
        end else begin
            rc_meta_ff <= rc_osc_pin;
            rc_sync_ff <= rc_meta_ff;
            rc_prev_ff <= rc_sync_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || restart || use_rc) begin
            div_cnt_ff <= '0;
        end else if (div_cnt_ff == div_last) begin
            div_cnt_ff <= '0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || restart) begin
            tad_tick <= 1'b0;
        end else if (use_rc) begin
            tad_tick <= rc_sync_ff & ~rc_prev_ff;
        end else begin
            tad_tick <= (div_cnt_ff == div_last);
        end
    end
endmodule
`default_nettype wire

// *** design/sacs_sar_core.sv ***
/*
 * Successive approximation register: holds the trial code shown to the
 * comparison DAC and resolves one bit per resolve strobe, MSB first.
 * Assumes cmp_high is already synchronised to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module sacs_sar_core (
    input  wire logic                          clk,       // system clock
    input  wire logic                          sys_rst,   // synchronous reset
    input  wire logic                          load,      // begin a new approximation
    input  wire logic                          resolve,   // decide current bit
    input  wire logic                          cmp_high,  // input at or above trial
    output logic [sacs_pkg::RESULT_W-1:0]      trial,     // code under test
    output logic [sacs_pkg::RESULT_W-1:0]      resolved   // trial with current bit decided
);
    logic [sacs_pkg::RESULT_W-1:0] mask_ff;

    assign resolved = cmp_high ? trial : (trial & ~mask_ff);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trial   <= '0;
            mask_ff <= '0;
        end else if (load) begin
            trial   <= sacs_pkg::SAR_FIRST_TRIAL;
            mask_ff <= sacs_pkg::SAR_FIRST_TRIAL;
        end else if (resolve) begin
            trial   <= resolved | (mask_ff >> 1);
            mask_ff <= mask_ff >> 1;
        end
    end
endmodule
`default_nettype wire

// *** design/sacs_sequencer.sv ***
/*
 * Control sequencer of a 10-bit successive approximation converter:
 * start, abort, completion, result formatting, done flag, interrupt
 * request and wake from sleep.
 * Assumes software controls arrive as same-clock levels and pulses;
 * comparator and RC oscillator come from outside and are synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
module sacs_sequencer (
    input  wire logic                          clk,                   // 25 MHz system clock
    input  wire logic                          sys_rst,               // synchronous reset
    input  wire sacs_pkg::sacs_cfg_type        cfg,                   // software configuration
    input  wire logic                          converter_on,          // converter enable
    input  wire logic                          go_set,                // write one to go
    input  wire logic                          go_clear,              // write zero to go
    input  wire logic                          done_clear,            // software clears done flag
    input  wire logic                          conversion_irq_enable, // interrupt enable
    input  wire logic                          global_irq_enable,     // global interrupt enable
    input  wire logic                          sleep_mode,            // device is asleep
    input  wire logic                          rc_osc_pin,            // dedicated RC oscillator
    input  wire logic                          cmp_pin,               // analog comparator output
    output logic                               convert_go_flag,       // go, cleared at completion
    output logic                               conversion_done_flag,  // sticky completion flag
    output logic                               irq_request,           // interrupt request
    output logic                               wake_pulse,            // wake from sleep
    output logic                               isr_branch_pulse,      // branch to handler
    output sacs_pkg::sacs_result_type          result,                // result_high / result_low
    output logic [3:0]                         mux_channel,           // analog mux select
    output logic                               ref_pos_external,      // positive ref is pin
    output logic                               ref_neg_ground,        // negative ref to ground
    output logic                               sample_hold,           // 1 hold, 0 acquire
    output logic                               converter_power,       // analog core powered
    output logic [sacs_pkg::RESULT_W-1:0]      dac_code               // trial code to DAC
);
    sacs_pkg::sacs_state_type          state_ff;
    sacs_pkg::sacs_state_type          nxt_state;
    logic [sacs_pkg::TAD_CNT_W-1:0]    tad_cnt_ff;
    logic [sacs_pkg::INSTR_CNT_W-1:0]  delay_cnt_ff;
    logic [sacs_pkg::INSTR_CNT_W-1:0]  wake_cnt_ff;
    logic                              wake_wait_ff;
    logic                              cmp_meta_ff;
    logic                              cmp_sync_ff;
    logic                              module_off_ff;
    logic                              tad_tick;
    logic                              tad_restart;
    logic                              sar_load;
    logic                              sar_resolve;
    logic [sacs_pkg::RESULT_W-1:0]     sar_trial;
    logic [sacs_pkg::RESULT_W-1:0]     sar_resolved;
    logic                              rc_selected;
    logic                              busy;
    logic                              last_tick;
    logic                              complete;
    logic                              start_ok;
    logic                              sleep_abort;
    logic                              nxt_irq;

    assign rc_selected = (cfg.conversion_clock_select[1:0] == sacs_pkg::CLKSEL_RC_TAIL);
    assign busy        = (state_ff == sacs_pkg::ST_RC_DELAY) || (state_ff == sacs_pkg::ST_SETUP)
                         || (state_ff == sacs_pkg::ST_CONVERT);
    assign last_tick   = tad_tick && (tad_cnt_ff == sacs_pkg::TAD_CNT_W'(sacs_pkg::TAD_PER_CONV - 1));
    assign complete    = (state_ff == sacs_pkg::ST_CONVERT) && last_tick && convert_go_flag;
    // a new start only from rest with the converter on; refused while aborting
    assign start_ok    = go_set && converter_on && !module_off_ff
                         && (state_ff == sacs_pkg::ST_IDLE);
    // sleep halts any conversion not clocked by the RC oscillator
    assign sleep_abort = sleep_mode && !rc_selected && busy;
    assign tad_restart = start_ok;
    assign sar_load    = (state_ff == sacs_pkg::ST_SETUP) && tad_tick && convert_go_flag;
    assign sar_resolve = (state_ff == sacs_pkg::ST_CONVERT) && tad_tick && convert_go_flag;
    assign nxt_irq     = conversion_done_flag && conversion_irq_enable;

    sacs_tad_clock u_tad_clock (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .clk_sel    (cfg.conversion_clock_select),
        .restart    (tad_restart),
        .rc_osc_pin (rc_osc_pin),
        .tad_tick   (tad_tick)
    );

    sacs_sar_core u_sar_core (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (sar_load),
        .resolve  (sar_resolve),
        .cmp_high (cmp_sync_ff),
        .trial    (sar_trial),
        .resolved (sar_resolved)
    );

    // comparator output is asynchronous to clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_meta_ff <= 1'b0;
            cmp_sync_ff <= 1'b0;
        end else begin
            cmp_meta_ff <= cmp_pin;
            cmp_sync_ff <= cmp_meta_ff;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sacs_pkg::ST_IDLE: begin
                if (start_ok) begin
                    nxt_state = rc_selected ? sacs_pkg::ST_RC_DELAY : sacs_pkg::ST_SETUP;
                end
            end
            sacs_pkg::ST_RC_DELAY: begin
                if (delay_cnt_ff == sacs_pkg::INSTR_CNT_W'(sacs_pkg::INSTR_CLKS - 1)) begin
                    nxt_state = sacs_pkg::ST_SETUP;
                end
            end
            sacs_pkg::ST_SETUP: begin
                if (tad_tick) begin
                    nxt_state = sacs_pkg::ST_CONVERT;
                end
            end
            sacs_pkg::ST_CONVERT: begin
                if (last_tick) begin
                    nxt_state = sacs_pkg::ST_IDLE;
                end
            end
            sacs_pkg::ST_ABORT: begin
                if (tad_tick && (tad_cnt_ff == sacs_pkg::TAD_CNT_W'(sacs_pkg::ABORT_TADS - 1))) begin
                    nxt_state = sacs_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = sacs_pkg::ST_IDLE;
            end
        endcase
        // software clearing go mid conversion aborts with a 2 period wait
        if (busy && !convert_go_flag) begin
            nxt_state = sacs_pkg::ST_ABORT;
        end
        if ((busy || state_ff == sacs_pkg::ST_ABORT) && (!converter_on || sleep_abort)) begin
            nxt_state = sacs_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= sacs_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // bit periods elapsed since the setup period began, or since the abort began
    always_ff @(posedge clk) begin
        if (sys_rst || state_ff != nxt_state && nxt_state != sacs_pkg::ST_CONVERT) begin
            tad_cnt_ff <= '0;
        end else if (tad_tick && (busy || state_ff == sacs_pkg::ST_ABORT)) begin
            tad_cnt_ff <= tad_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || state_ff != sacs_pkg::ST_RC_DELAY) begin
            delay_cnt_ff <= '0;
        end else begin
            delay_cnt_ff <= delay_cnt_ff + 3'h1;
        end
    end

    // software set wins over a same-cycle hardware clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            convert_go_flag <= 1'b0;
        end else if (start_ok) begin
            convert_go_flag <= 1'b1;
        end else if (go_clear || complete || sleep_abort || !converter_on) begin
            convert_go_flag <= 1'b0;
        end
    end

    // the set wins, so a completion in the clearing cycle is never lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conversion_done_flag <= 1'b0;
        end else if (complete) begin
            conversion_done_flag <= 1'b1;
        end else if (done_clear) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // aborted conversions never reach here, so the old pair stays
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result.result_high <= sacs_pkg::RESULT_RST;
            result.result_low  <= sacs_pkg::RESULT_RST;
        end else if (complete) begin
            if (cfg.result_justify == sacs_pkg::JUSTIFY_RIGHT) begin
                result.result_high <= {6'h00, sar_resolved[9:8]};
                result.result_low  <= sar_resolved[7:0];
            end else begin
                result.result_high <= sar_resolved[9:2];
                result.result_low  <= {sar_resolved[1:0], 6'h00};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= nxt_irq;
        end
    end

    // wake on a rising request while asleep; handler branch one instruction later
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= sleep_mode && nxt_irq && !irq_request;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_wait_ff     <= 1'b0;
            wake_cnt_ff      <= '0;
            isr_branch_pulse <= 1'b0;
        end else begin
            isr_branch_pulse <= 1'b0;
            if (wake_pulse) begin
                wake_wait_ff <= 1'b1;
                wake_cnt_ff  <= '0;
            end else if (wake_wait_ff) begin
                wake_cnt_ff <= wake_cnt_ff + 3'h1;
                if (wake_cnt_ff == sacs_pkg::INSTR_CNT_W'(sacs_pkg::INSTR_CLKS - 1)) begin
                    wake_wait_ff     <= 1'b0;
                    isr_branch_pulse <= global_irq_enable;
                end
            end
        end
    end

    // asleep, the core powers down after a halt or a silent RC completion
    always_ff @(posedge clk) begin
        if (sys_rst || !sleep_mode) begin
            module_off_ff <= 1'b0;
        end else if (sleep_abort || (complete && !conversion_irq_enable)) begin
            module_off_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            converter_power <= 1'b0;
        end else begin
            converter_power <= converter_on && !module_off_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mux_channel      <= sacs_pkg::CHANNEL_RST;
            ref_pos_external <= 1'b0;
            ref_neg_ground   <= 1'b1;
        end else begin
            mux_channel      <= cfg.channel_select;
            ref_pos_external <= cfg.reference_select;
            ref_neg_ground   <= 1'b1;
        end
    end

    // hold from the setup period to the end; acquisition otherwise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_hold <= 1'b0;
            dac_code    <= '0;
        end else begin
            sample_hold <= (nxt_state == sacs_pkg::ST_SETUP) || (nxt_state == sacs_pkg::ST_CONVERT);
            dac_code    <= sar_trial;
        end
    end
endmodule
`default_nettype wire

// *** bench/sacs_analog_model.sv ***
/* analog side model: input mux, references and comparator of the core
   assumes dac_code is the trial code and levels are fixed per channel */
`timescale 1ns/1ns
`default_nettype none
module sacs_analog_model (
    input  wire logic                          clk,              // system clock
    input  wire logic [3:0]                    mux_channel,      // selected input
    input  wire logic                          ref_pos_external, // half-supply pin ref
    input  wire logic                          converter_power,  // core powered
    input  wire logic [sacs_pkg::RESULT_W-1:0] dac_code,         // trial code
    output var  logic                          cmp_pin           // input at or above trial
);
    logic [10:0] level;
    logic        junk_ff = 1'h0;

    // each channel gets its own level so a wrong route shows
    always_comb level = ref_pos_external ? {mux_channel, 6'h2d, 1'h0} : {1'h0, mux_channel, 6'h2d};
    always_ff @(posedge clk) junk_ff <= ~junk_ff;
    // unpowered comparator gives no usable answer
    always_comb cmp_pin = converter_power ? (level >= {1'h0, dac_code}) : junk_ff;
endmodule
`default_nettype wire

// *** bench/sacs_checker.sv ***
/* port assertions for the converter sequencer
   assumes one clock and synchronous active high reset */
`timescale 1ns/1ns
`default_nettype none
module sacs_checker (
    input wire logic                      clk,                   // clock
    input wire logic                      sys_rst,               // reset
    input wire sacs_pkg::sacs_cfg_type    cfg,                   // config
    input wire logic                      converter_on,          // enable
    input wire logic                      go_set,                // start
    input wire logic                      done_clear,            // flag clear
    input wire logic                      conversion_irq_enable, // irq enable
    input wire logic                      global_irq_enable,     // global enable
    input wire logic                      sleep_mode,            // asleep
    input wire logic                      convert_go_flag,       // go
    input wire logic                      conversion_done_flag,  // done
    input wire logic                      irq_request,           // irq
    input wire logic                      wake_pulse,            // wake
    input wire logic                      isr_branch_pulse,      // branch
    input wire sacs_pkg::sacs_result_type result,                // result pair
    input wire logic [3:0]                mux_channel,           // mux select
    input wire logic                      ref_neg_ground         // neg ref
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_wake;
        wake_pulse; // launched on the same edge as the request
    endsequence
    sequence s_branch;
        ##[4:6] isr_branch_pulse;
    endsequence

    neg_ref_a: assert property (ref_neg_ground) else $error("negative ref off ground");
    mux_route_a: assert property (!$past(sys_rst) |-> mux_channel == $past(cfg.channel_select))
        else $error("mux not following channel");
    done_sticky_a: assert property (conversion_done_flag && !done_clear |=> conversion_done_flag)
        else $error("done flag dropped");
    done_ends_go_a: assert property ($rose(conversion_done_flag) |-> $fell(convert_go_flag))
        else $error("done without go clear");
    go_cause_a: assert property ($rose(convert_go_flag) |-> $past(go_set) && $past(converter_on))
        else $error("go rose without start");
    go_bounded_a: assert property ($rose(convert_go_flag) |-> ##[1:1000] !convert_go_flag)
        else $error("conversion too long");
    irq_follow_a: assert property (!$past(sys_rst) |->
        irq_request == $past(conversion_done_flag && conversion_irq_enable))
        else $error("irq not following flag");
    result_when_a: assert property (!$past(sys_rst) && $changed(result) |-> $fell(convert_go_flag))
        else $error("result moved outside completion");
    right_pad_a: assert property (!$past(sys_rst) && $changed(result) && $past(cfg.result_justify)
        |-> result.result_high[7:2] == 6'h00) else $error("right format pad");
    left_pad_a: assert property (!$past(sys_rst) && $changed(result) && !$past(cfg.result_justify)
        |-> result.result_low[5:0] == 6'h00) else $error("left format pad");
    wake_irq_a: assert property ($rose(irq_request) && sleep_mode |-> s_wake)
        else $error("no wake");
    branch_on_a: assert property (wake_pulse && global_irq_enable |-> s_branch)
        else $error("no branch");
    branch_off_a: assert property (wake_pulse && !global_irq_enable |=> !isr_branch_pulse [*6])
        else $error("branch while disabled");
endmodule
bind sacs_sequencer sacs_checker chk_u (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
    .converter_on(converter_on), .go_set(go_set), .done_clear(done_clear),
    .conversion_irq_enable(conversion_irq_enable), .global_irq_enable(global_irq_enable),
    .sleep_mode(sleep_mode), .convert_go_flag(convert_go_flag), .conversion_done_flag(conversion_done_flag),
    .irq_request(irq_request), .wake_pulse(wake_pulse), .isr_branch_pulse(isr_branch_pulse),
    .result(result), .mux_channel(mux_channel), .ref_neg_ground(ref_neg_ground));
`default_nettype wire

// *** bench/sar_adc_control_sequencer_test.sv ***
/* self-checking bench for the converter sequencer
   assumes inputs change at posedge and outputs settle by negedge */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_sequencer_test;
    logic                      clk = 1'h0;
    logic                      sys_rst = 1'h1;
    sacs_pkg::sacs_cfg_type    cfg = '0;
    logic                      on = 1'h0;
    logic                      go_set = 1'h0;
    logic                      go_clear = 1'h0;
    logic                      done_clear = 1'h0;
    logic                      irq_en = 1'h0;
    logic                      glob_en = 1'h0;
    logic                      sleep_mode = 1'h0;
    logic                      rc_osc_pin = 1'h0;
    logic                      cmp_pin, go, done, irq, wake, branch, ref_ext, ref_gnd, hold, power;
    sacs_pkg::sacs_result_type result;
    logic [3:0]                mux_channel;
    logic [9:0]                dac_code;
    int                        n_errors = 0;
    int                        n_checks = 0;
    int                        cycles = 0;
    int                        cyc;

    always #20 clk = ~clk;
    always #230 rc_osc_pin = ~rc_osc_pin; // unrelated phase, far slower

    sacs_sequencer dut_u (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .converter_on(on), .go_set(go_set),
        .go_clear(go_clear), .done_clear(done_clear), .conversion_irq_enable(irq_en),
        .global_irq_enable(glob_en), .sleep_mode(sleep_mode), .rc_osc_pin(rc_osc_pin), .cmp_pin(cmp_pin),
        .convert_go_flag(go), .conversion_done_flag(done), .irq_request(irq), .wake_pulse(wake),
        .isr_branch_pulse(branch), .result(result), .mux_channel(mux_channel), .ref_pos_external(ref_ext),
        .ref_neg_ground(ref_gnd), .sample_hold(hold), .converter_power(power), .dac_code(dac_code));
    sacs_analog_model model_u (.clk(clk), .mux_channel(mux_channel), .ref_pos_external(ref_ext),
        .converter_power(power), .dac_code(dac_code), .cmp_pin(cmp_pin));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [15:0] expect_of(input logic [3:0] ch, input logic ext, input logic just);
        logic [10:0] v;
        v = ext ? {ch, 6'h2d, 1'h0} : {1'h0, ch, 6'h2d};
        if (v > 11'h3ff)
            v = 11'h3ff;
        return just ? {6'h00, v[9:0]} : {v[9:0], 6'h00};
    endfunction

    task automatic start(input logic [2:0] code, input logic [3:0] ch, input logic ext, input logic just);
        @(posedge clk);
        cfg <= '{just, ext, ch, code};
        repeat (8) @(posedge clk);
        go_set <= 1'h1;
        @(posedge clk);
        go_set <= 1'h0;
    endtask

    task automatic wait_idle();
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (go === 1'h1 && cyc < 3000);
    endtask

    task automatic clear_done();
        @(posedge clk);
        done_clear <= 1'h1;
        @(posedge clk);
        done_clear <= 1'h0;
        @(negedge clk);
        check("done cleared", 16'h0, 16'(done));
    endtask

    task automatic t_off();
        start(3'h0, 4'h1, 1'h0, 1'h1);
        repeat (4) @(negedge clk);
        check("go while off", 16'h0, 16'(go));
        @(posedge clk);
        on <= 1'h1; // enable first, start later
        repeat (8) @(posedge clk);
        $display("test off done");
    endtask

    task automatic t_clocks();
        int n;
        for (int k = 0; k < 8; k++) begin
            start(k[2:0], k[3:0] | {4{!k}}, k % 5 == 0, k[0]); // full scale: Fosc/2 outruns the comparator sync
            wait_idle();
            n = 2 << (2 * k[1:0] + k[2]);
            if (k[1:0] != 2'h3)
                check("cycle window", 16'h1, 16'(cyc >= 11 * n && cyc <= 12 * n + 4));
            check("result", expect_of(k[3:0] | {4{!k}}, k % 5 == 0, k[0]), result);
            repeat (3) @(negedge clk);
            check("done sticky", 16'h1, 16'(done));
            check("no irq", 16'h0, 16'(irq));
            clear_done();
        end
        $display("test clocks done");
    endtask

    task automatic t_abort();
        logic [15:0] old;
        old = result;
        start(3'h6, 4'h5, 1'h0, 1'h1);
        repeat (100) @(posedge clk);
        go_clear <= 1'h1;
        @(posedge clk);
        go_clear <= 1'h0;
        go_set <= 1'h1; // lands just after go clears, one cycle before the abort wait
        @(posedge clk);
        go_set <= 1'h0;
        repeat (20) @(negedge clk);
        check("abort go", 16'h0, 16'(go));
        check("abort result", old, result);
        check("abort done", 16'h0, 16'(done));
        check("abort hold", 16'h0, 16'(hold));
        repeat (140) @(posedge clk);
        start(3'h6, 4'h5, 1'h0, 1'h1);
        wait_idle();
        check("after abort", expect_of(4'h5, 1'h0, 1'h1), result);
        clear_done();
        $display("test abort done");
    endtask

    task automatic t_sleep(input logic g);
        int w = 0;
        start(3'h3, 4'h2, 1'h0, 1'h1);
        glob_en <= g;
        irq_en <= 1'h1;
        sleep_mode <= 1'h1; // within the rc start delay
        do begin
            @(negedge clk);
            w++;
        end while (wake !== 1'h1 && w < 3000);
        check("irq raised", 16'h1, 16'(irq));
        check("woken", 16'h1, 16'(wake));
        check("sleep result", expect_of(4'h2, 1'h0, 1'h1), result);
        w = 0;
        repeat (8) begin
            @(negedge clk);
            if (branch === 1'h1)
                w++;
        end
        check("handler branch", 16'(g), 16'(w));
        @(posedge clk);
        sleep_mode <= 1'h0;
        irq_en <= 1'h0;
        clear_done();
        $display("test sleep done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        @(negedge clk);
        check("reset result", 16'h0, result);
        check("ground ref", 16'h1, 16'(ref_gnd));
        t_off();
        t_clocks();
        t_abort();
        t_sleep(1'h1);
        t_sleep(1'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
